// file: bench/tprt_pin_model.sv
`timescale 1ns/100ps
module tprt_pin_model (
	// shared pin and switch
	input wire logic pinOut,
	input wire logic pinOe_n,
	input wire logic switchLevel,
	output logic pinIn
);
	// device drive overrides the switch, as on the real wire
	assign pinIn = !pinOe_n ? pinOut : switchLevel;
endmodule

// file: bench/tprt_top_bench.sv
`timescale 1ns/100ps
module tprt_top_bench
	import tprt_pkg::*;
;
	logic mclk = 1'b0, rst_n = 1'b0, sysReset = 1'b0, mainPowerOff = 1'b0;
	logic regWrEn = 1'b0, regRdEn = 1'b0, alarmEvent = 1'b0, secondEvent = 1'b0;
	logic switchLevel = 1'b0;
	logic [REG_AW-1:0] regAddr = 8'h00;
	logic [REG_DW-1:0] regWrData = 16'h0000;
	logic [REG_DW-1:0] regRdData;
	logic pinIn, pinOut, pinOe_n, rtcTick, backupWipe, intrusionIrq;
	int badCount = 0;
	int nChecks = 0;
	int hi, rs;
	tprt_top i_dut (.mclk, .rst_n, .sysReset, .mainPowerOff, .regWrEn, .regRdEn, .regAddr,
		.regWrData, .regRdData, .alarmEvent, .secondEvent, .pinIn, .pinOut, .pinOe_n,
		.rtcTick, .backupWipe, .intrusionIrq);
	tprt_pin_model i_pin (.pinOut, .pinOe_n, .switchLevel, .pinIn);
	initial begin
		forever #4 mclk = ~mclk;
	end
	task automatic step();
		@(posedge mclk) #1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nChecks++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
		{regAddr, regWrData, regWrEn} = {a, d, 1'b1};
		step();
		regWrEn = 1'b0;
		step();
	endtask
	task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
		{regAddr, regRdEn} = {a, 1'b1};
		step();
		regRdEn = 1'b0;
		chk(regRdData, e);
		step();
	endtask
	task automatic sample(input int s, input int n);
		logic p, v;
		hi = 0;
		rs = 0;
		p = pinOut;
		repeat (n) begin
			step();
			v = s == 0 ? pinOut : s == 1 ? rtcTick : backupWipe;
			hi += int'(v === 1'b1);
			rs += int'(v === 1'b1 && p === 1'b0);
			p = v;
		end
	endtask
	task automatic fire(input logic sel, input logic mode);
		logic p0;
		p0 = pinOut;
		{alarmEvent, secondEvent} = {sel, !sel};
		step();
		{alarmEvent, secondEvent} = {!sel, sel};
		chk(pinOut, p0);
		step();
		{alarmEvent, secondEvent} = 2'b00;
		chk({pinOe_n, pinOut}, {1'b0, mode ? !p0 : 1'b1});
		step();
		chk(pinOut, mode ? !p0 : 1'b0);
	endtask
	task automatic tamper(input logic pol);
		switchLevel = pol;
		wr(OFS_CTRL, {14'h0, pol, 1'b0});
		wr(OFS_STAT, {13'h0, pol, 2'b00});
		wr(OFS_CTRL, {14'h0, pol, 1'b1});
		switchLevel = !pol;
		step();
		chk({backupWipe, intrusionIrq}, {1'b1, pol});
		sample(2, 6);
		chk(16'(hi), 16'h0000);
		wr(OFS_STAT, {13'h0, pol, 2'b00});
		rd(OFS_STAT, {6'h0, pol, 1'b1, 5'h0, pol, 2'b00});
		wr(OFS_STAT, {13'h0, pol, 2'b11});
		rd(OFS_STAT, {13'h0, pol, 2'b00});
		wr(OFS_CTRL, {14'h0, pol, 1'b0});
		sample(2, 4);
		chk(16'(hi), 16'h0000);
		wr(OFS_CTRL, {14'h0, pol, 1'b1});
		chk(backupWipe, 1'b1);
		switchLevel = pol;
		wr(OFS_CTRL, {14'h0, pol, 1'b0});
	endtask
	task automatic endOfTest();
		$display("checks=%0d errors=%0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		wr(OFS_TRIM, 16'h007F);
		sample(1, 256);
		// drops start at window begin, so a few fall before the sample
		chk(hi >= 129 && hi <= 138, 1'b1);
		rd(OFS_TRIM, 16'h007F);
		rd(OFS_CTRL, 16'h0000);
		rd(8'h40, 16'h0000);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_TRIM, {4'h0, m[1], 1'b0, m[0], 9'h100});
			fire(m[0], m[1]);
		end
		wr(OFS_TRIM, 16'h0F80);
		sample(0, 256);
		chk(16'(hi), 16'h0080);
		chk(16'(rs), 16'h0004);
		sysReset = 1'b1;
		step();
		sysReset = 1'b0;
		rd(OFS_TRIM, 16'h0F80);
		mainPowerOff = 1'b1;
		step();
		mainPowerOff = 1'b0;
		rd(OFS_TRIM, 16'h0F00);
		wr(OFS_TRIM, 16'h0080);
		chk(pinOe_n, 1'b1);
		wr(OFS_TRIM, 16'h0000);
		tamper(1'b0);
		tamper(1'b1);
		wr(OFS_TRIM, 16'h0100);
		wr(OFS_CTRL, 16'h0003);
		sample(2, 8);
		chk(16'(hi), 16'h0000);
		// irq flag left set by the enable-on-active hit; system reset drops only it
		chk(intrusionIrq, 1'b1);
		sysReset = 1'b1;
		step();
		sysReset = 1'b0;
		chk(intrusionIrq, 1'b0);
		rd(OFS_STAT, 16'h0104);
		endOfTest();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		badCount++;
		endOfTest();
	end
endmodule

// file: bench/tprt_top_monitor.sv
`timescale 1ns/100ps
module tprt_top_monitor
	import tprt_pkg::*;
(
	// watched top ports
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sysReset,
	input wire logic mainPowerOff,
	input wire logic regWrEn,
	input wire logic [REG_AW-1:0] regAddr,
	input wire logic [REG_DW-1:0] regWrData,
	input wire logic pinOe_n,
	input wire logic rtcTick,
	input wire logic backupWipe,
	input wire logic intrusionIrq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_wipe; backupWipe |=> !backupWipe; endproperty
	a_wipe: assert property (p_wipe) else $error("wipe too long");
	property p_block; backupWipe |-> $past(pinOe_n); endproperty
	a_block: assert property (p_block) else $error("wipe while driving");
	property p_irqset; $rose(intrusionIrq) |-> backupWipe; endproperty
	a_irqset: assert property (p_irqset) else $error("irq without event");
	property p_irqclr;
		regWrEn && regAddr == OFS_STAT && regWrData[STAT_IFCLR_BIT]
		|=> !intrusionIrq || backupWipe;
	endproperty
	a_irqclr: assert property (p_irqclr) else $error("irq not cleared");
	property p_hold; intrusionIrq && !regWrEn && !sysReset |=> intrusionIrq; endproperty
	a_hold: assert property (p_hold) else $error("irq lost");
	property p_sys; sysReset |=> !intrusionIrq || backupWipe; endproperty
	a_sys: assert property (p_sys) else $error("irq kept over sys reset");
	property p_oe; !$past(regWrEn) && !$past(mainPowerOff) |-> $stable(pinOe_n); endproperty
	a_oe: assert property (p_oe) else $error("pin drive changed");
	property p_rst;
		disable iff (1'b0) !rst_n |=> pinOe_n && !backupWipe && !intrusionIrq && !rtcTick;
	endproperty
	a_rst: assert property (p_rst) else $error("not idle in reset");
endmodule

bind tprt_top tprt_top_monitor i_mon (.mclk, .rst_n, .sysReset, .mainPowerOff, .regWrEn,
	.regAddr, .regWrData, .pinOe_n, .rtcTick, .backupWipe, .intrusionIrq);

// file: common/tprt_pkg.sv
package tprt_pkg;

	localparam int REG_AW = 8;
	localparam int REG_DW = 16;

	// register byte offsets
	localparam logic [REG_AW-1:0] OFS_TRIM = 8'h2C;
	localparam logic [REG_AW-1:0] OFS_CTRL = 8'h30;
	localparam logic [REG_AW-1:0] OFS_STAT = 8'h34;

	// rtc_trim_and_pin_output fields
	localparam int TRIM_DROP_LSB = 0;
	localparam int TRIM_DROP_W = 7;
	localparam int TRIM_CAL_CLOCK_OUTPUT_BIT = 7;
	localparam int TRIM_EVENT_OUTPUT_ENABLE_BIT = 8;
	localparam int TRIM_EVENT_SOURCE_SELECT_BIT = 9;
	localparam int TRIM_CALSEL_BIT = 10;
	localparam int TRIM_OUTMODE_BIT = 11;

	// tamper_pin_control fields
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_POL_BIT = 1;

	// control/status fields
	localparam int STAT_EFCLR_BIT = 0;
	localparam int STAT_IFCLR_BIT = 1;
	localparam int STAT_IEN_BIT = 2;
	localparam int STAT_EF_BIT = 8;
	localparam int STAT_IF_BIT = 9;

	// reset values
	localparam logic [TRIM_DROP_W-1:0] DROP_RST = 7'h00;
	localparam logic [REG_DW-1:0] RDATA_RST = 16'h0000;

	// calibration window and output divider
	localparam int WIN_BITS = 20;
	localparam int DIV_BITS = 6;
	localparam logic [WIN_BITS-1:0] WIN_RST = 20'h00000;
	localparam logic [DIV_BITS-1:0] DIV_RST = 6'h00;
	localparam logic [WIN_BITS-1:0] WIN_STEP = 20'h00001;
	localparam logic [DIV_BITS-1:0] DIV_STEP = 6'h01;

endpackage

// file: rtl/tprt_cal_trim.sv
`timescale 1ns/100ps
module tprt_cal_trim
	import tprt_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// control
	input wire logic [TRIM_DROP_W-1:0] dropCount,
	// outputs
	output logic rtcTick,
	output logic calClk
);

	typedef struct packed {
		logic [WIN_BITS-1:0] winCnt;
		logic [DIV_BITS-1:0] divCnt;
		logic tick;
	} tprt_cal_t;

	tprt_cal_t cal_q;
	tprt_cal_t cal_d;

	// drops bunch at window start: cheap, and the long-term rate is what matters
	always_comb begin
		cal_d = cal_q;
		cal_d.winCnt = cal_q.winCnt + WIN_STEP;
		// widened compare so the full 7-bit range reaches 127 clocks, above 121 ppm
		cal_d.tick = (cal_q.winCnt >= WIN_BITS'(dropCount)) ? 1'b1 : 1'b0;
		cal_d.divCnt = cal_q.divCnt + DIV_STEP;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cal_q.winCnt <= WIN_RST;
			cal_q.divCnt <= DIV_RST;
			cal_q.tick <= 1'b0;
		end else begin
			cal_q <= cal_d;
		end
	end

	assign rtcTick = cal_q.tick;
	assign calClk = cal_q.divCnt[DIV_BITS-1];

endmodule

// file: rtl/tprt_top.sv
`timescale 1ns/100ps
module tprt_top
	import tprt_pkg::*;
(
	// clock and battery-domain reset
	input wire logic mclk,
	input wire logic rst_n,
	// system-side resets and supply state
	input wire logic sysReset,
	input wire logic mainPowerOff,
	// register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [REG_AW-1:0] regAddr,
	input wire logic [REG_DW-1:0] regWrData,
	output logic [REG_DW-1:0] regRdData,
	// rtc events
	input wire logic alarmEvent,
	input wire logic secondEvent,
	// tamper pin
	input wire logic pinIn,
	output logic pinOut,
	output logic pinOe_n,
	// to rtc and backup storage
	output logic rtcTick,
	output logic backupWipe,
	output logic intrusionIrq
);

	typedef struct packed {
		logic [TRIM_DROP_W-1:0] clockDropCount;
		logic calClockOutput;
		logic eventOutputEnable;
		logic eventSourceSelect;
		logic calClockOutputSelect;
		logic pinOutputMode;
		logic intrusionDetectEnable;
		logic intrusionPolarity;
		logic intrusionIrqEnable;
		logic intrusionEventFlag;
		logic intrusionIrqFlag;
		logic activeSeen;
		logic eventPulse;
		logic toggleLevel;
		logic wipe;
		logic [REG_DW-1:0] rdData;
	} tprt_state_t;

	tprt_state_t st_q;
	tprt_state_t st_d;

	logic calClk;
	logic wrTrim;
	logic wrCtrl;
	logic wrStat;
	logic selEvent;
	logic calDrive;
	logic detectOn;
	logic pinActive;
	logic intrusionHit;
	logic efClear;
	logic ifClear;

	tprt_cal_trim u_cal (
		.mclk(mclk),
		.rst_n(rst_n),
		.dropCount(st_q.clockDropCount),
		.rtcTick(rtcTick),
		.calClk(calClk)
	);

	assign wrTrim = regWrEn && (regAddr == OFS_TRIM);
	assign wrCtrl = regWrEn && (regAddr == OFS_CTRL);
	assign wrStat = regWrEn && (regAddr == OFS_STAT);

	// source mux for the event output
	assign selEvent = st_q.eventSourceSelect ? secondEvent : alarmEvent;
	// both bits must be set before the divided clock appears
	assign calDrive = st_q.calClockOutput && st_q.calClockOutputSelect;
	// any pin output use steals the pin from detection
	assign detectOn = st_q.intrusionDetectEnable && !st_q.eventOutputEnable
		&& !st_q.calClockOutput;
	// polarity 0 active high, 1 active low
	assign pinActive = st_q.intrusionPolarity ? ~pinIn : pinIn;
	// level-qualified edge: enabling on an active pin still fires once
	assign intrusionHit = detectOn && pinActive && !st_q.activeSeen;
	assign efClear = wrStat && regWrData[STAT_EFCLR_BIT];
	assign ifClear = wrStat && regWrData[STAT_IFCLR_BIT];

	always_comb begin
		st_d = st_q;
		// reserved bits are simply not stored; software keeps them zero
		if (wrTrim) begin
			st_d.clockDropCount = regWrData[TRIM_DROP_LSB +: TRIM_DROP_W];
			st_d.calClockOutput = regWrData[TRIM_CAL_CLOCK_OUTPUT_BIT];
			st_d.eventOutputEnable = regWrData[TRIM_EVENT_OUTPUT_ENABLE_BIT];
			st_d.eventSourceSelect = regWrData[TRIM_EVENT_SOURCE_SELECT_BIT];
			st_d.calClockOutputSelect = regWrData[TRIM_CALSEL_BIT];
			st_d.pinOutputMode = regWrData[TRIM_OUTMODE_BIT];
		end
		// supply loss beats a same-cycle write
		if (mainPowerOff) begin
			st_d.calClockOutput = 1'b0;
		end
		// polarity taken as written; glitch-free change is software's job
		if (wrCtrl) begin
			st_d.intrusionDetectEnable = regWrData[CTRL_EN_BIT];
			st_d.intrusionPolarity = regWrData[CTRL_POL_BIT];
		end
		if (wrStat) begin
			st_d.intrusionIrqEnable = regWrData[STAT_IEN_BIT];
		end

		// detection tracking: cleared when inactive or disabled to re-arm
		st_d.activeSeen = detectOn && pinActive;
		st_d.wipe = intrusionHit;

		// flags: clear first, then set so a same-cycle event wins
		if (efClear) begin
			st_d.intrusionEventFlag = 1'b0;
		end
		if (ifClear || sysReset) begin
			st_d.intrusionIrqFlag = 1'b0;
		end
		if (intrusionHit) begin
			st_d.intrusionEventFlag = 1'b1;
			if (st_q.intrusionIrqEnable) begin
				st_d.intrusionIrqFlag = 1'b1;
			end
		end

		// pin event output
		st_d.eventPulse = selEvent;
		if (st_q.eventOutputEnable && st_q.pinOutputMode && selEvent) begin
			st_d.toggleLevel = ~st_q.toggleLevel;
		end

		// read data registered one cycle after the strobe
		if (regRdEn) begin
			st_d.rdData = RDATA_RST;
			unique case (regAddr)
				OFS_TRIM: begin
					st_d.rdData[TRIM_DROP_LSB +: TRIM_DROP_W] = st_q.clockDropCount;
					st_d.rdData[TRIM_CAL_CLOCK_OUTPUT_BIT] = st_q.calClockOutput;
					st_d.rdData[TRIM_EVENT_OUTPUT_ENABLE_BIT] = st_q.eventOutputEnable;
					st_d.rdData[TRIM_EVENT_SOURCE_SELECT_BIT] = st_q.eventSourceSelect;
					st_d.rdData[TRIM_CALSEL_BIT] = st_q.calClockOutputSelect;
					st_d.rdData[TRIM_OUTMODE_BIT] = st_q.pinOutputMode;
				end
				OFS_CTRL: begin
					st_d.rdData[CTRL_EN_BIT] = st_q.intrusionDetectEnable;
					st_d.rdData[CTRL_POL_BIT] = st_q.intrusionPolarity;
				end
				OFS_STAT: begin
					// clear bits are write-only and read as zero
					st_d.rdData[STAT_IEN_BIT] = st_q.intrusionIrqEnable;
					st_d.rdData[STAT_EF_BIT] = st_q.intrusionEventFlag;
					st_d.rdData[STAT_IF_BIT] = st_q.intrusionIrqFlag;
				end
				default: begin
					st_d.rdData = RDATA_RST;
				end
			endcase
		end
	end

	// only the battery-domain reset clears the whole configuration; supply loss clears calClockOutput alone
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q.clockDropCount <= DROP_RST;
			st_q.calClockOutput <= 1'b0;
			st_q.eventOutputEnable <= 1'b0;
			st_q.eventSourceSelect <= 1'b0;
			st_q.calClockOutputSelect <= 1'b0;
			st_q.pinOutputMode <= 1'b0;
			st_q.intrusionDetectEnable <= 1'b0;
			st_q.intrusionPolarity <= 1'b0;
			st_q.intrusionIrqEnable <= 1'b0;
			st_q.intrusionEventFlag <= 1'b0;
			st_q.intrusionIrqFlag <= 1'b0;
			st_q.activeSeen <= 1'b0;
			st_q.eventPulse <= 1'b0;
			st_q.toggleLevel <= 1'b0;
			st_q.wipe <= 1'b0;
			st_q.rdData <= RDATA_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// pin drive: calibration clock over event output, else released
	always_comb begin
		pinOut = 1'b0;
		pinOe_n = 1'b1;
		if (calDrive) begin
			pinOut = calClk;
			pinOe_n = 1'b0;
		end else if (st_q.eventOutputEnable) begin
			pinOut = st_q.pinOutputMode ? st_q.toggleLevel : st_q.eventPulse;
			pinOe_n = 1'b0;
		end
	end

	assign regRdData = st_q.rdData;
	assign backupWipe = st_q.wipe;
	assign intrusionIrq = st_q.intrusionIrqFlag;

endmodule
